// [logic/touch_pkg.sv]
// constants shared by the capacitive touch measurement block
package touch_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] UNIT_CONTROL_OFS = 4'h0;
	localparam logic [3:0] MEASURE_MODE_OFS = 4'h1;
	localparam logic [3:0] CHANNEL_CONTROL_OFS = 4'h2;
	localparam logic [3:0] CHANNEL_ENABLE_OFS = 4'h3;
	localparam logic [3:0] THRESHOLD_CONTROL_OFS = 4'h4;
	localparam logic [3:0] SECONDARY_PRESET_OFS = 4'h5;
	localparam logic [3:0] UNIT_FLAG_OFS = 4'h6;
	localparam logic [3:0] FIRST_RESULT_OFS = 4'h7;
	localparam logic [3:0] SECOND_RESULT_OFS = 4'h8;
	localparam logic [3:0] UNIT_STATUS_OFS = 4'h9;

	// ****************************************
	// field positions
	// ****************************************
	localparam int START_BIT = 0;
	localparam int TRIG_LSB = 0;
	localparam int PRE_EN_BIT = 2;
	localparam int CHSEL_LSB = 0;
	localparam int SCAN_SEL_BIT = 3;
	localparam int SCAN_ORDER_BIT = 4;
	localparam int FLAG_BIT = 0;

	// ****************************************
	// encodings and reset values
	// ****************************************
	localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
	localparam logic [1:0] TRIG_TIMER = 2'h2;
	localparam logic [1:0] TRIG_EXTERNAL = 2'h3;
	localparam logic [7:0] CHANNEL_ENABLE_RST = 8'h00;
	localparam logic [4:0] SECONDARY_PRESET_RST = 5'h07;
	localparam logic [1:0] THRESHOLD_RST = 2'h0;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int UNIT_HZ = 5_000_000;
	localparam int UNIT_DIV = CLK_HZ / UNIT_HZ;
	localparam int CHARGE_TICKS = 8;
	localparam int DISCHARGE_TICKS = 2;
	localparam int SETTLE_TICKS = 2;

endpackage

// [logic/touch_count_unit.sv]
// primary and secondary counters with the two result latches
`timescale 1ns/1ps
module touch_count_unit #(
	parameter int PW = 9,
	parameter int SW = 5
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clear,
	input wire logic sample_en,
	input wire logic pre_en,
	input wire logic pre_hi,
	input wire logic main_hi,
	input wire logic [SW-1:0] preset,
	output logic [PW-1:0] primary_ff,
	output logic [SW-1:0] secondary_ff,
	output logic step2_ff,
	output logic done_ff,
	output logic [PW-1:0] data1_ff,
	output logic [PW-1:0] data2_ff
);

	wire pre_term = pre_en & pre_hi;
	wire [1:0] inc = {1'b0, pre_term} + {1'b0, main_hi};
	wire [PW-1:0] nxt_primary = primary_ff + PW'(inc);
	wire leave_step1 = ~main_hi & ~pre_term;
	wire at_cap = secondary_ff >= preset;
	// the second stage alone moves it; highs never pass the preset
	wire [SW-1:0] nxt_secondary = main_hi ? (at_cap ? preset : secondary_ff + 1'b1) :
		secondary_ff - 1'b1;
	wire hit_zero = ~main_hi & (secondary_ff == SW'(1));

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			primary_ff <= '0;
			secondary_ff <= '0;
			step2_ff <= 1'b0;
			done_ff <= 1'b0;
			data1_ff <= '0;
			data2_ff <= '0;
		end else if (clear) begin
			primary_ff <= '0;
			secondary_ff <= preset;
			step2_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (sample_en & ~done_ff) begin
			primary_ff <= nxt_primary;
			if (!step2_ff) begin
				// secondary held at preset until step two
				if (leave_step1) begin
					step2_ff <= 1'b1;
					data1_ff <= nxt_primary;
				end
			end else begin
				secondary_ff <= nxt_secondary;
				if (hit_zero) begin
					done_ff <= 1'b1;
					data2_ff <= nxt_primary;
				end
			end
		end
	end

endmodule

// [logic/touch_measure.sv]
// capacitive touch measurement sequencer with register port
`timescale 1ns/1ps
module touch_measure #(
	parameter int CHANNELS = 8,
	parameter int PW = 9,
	parameter int SW = 5
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [touch_pkg::ADDR_W-1:0] addr,
	input wire logic [touch_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [touch_pkg::DATA_W-1:0] rd_data_ff,
	input wire logic sense_pin_i,
	output logic sense_pin_o_ff,
	output logic sense_pin_oe_n_ff,
	output logic discharge_pin_o_ff,
	output logic discharge_pin_oe_n_ff,
	output logic charge_pin_o_ff,
	output logic charge_pin_oe_n_ff,
	output logic [CHANNELS-1:0] channel_on_ff,
	output logic [1:0] threshold_field_ff,
	input wire logic compare_match_flag,
	input wire logic external_trigger_pin,
	input wire logic external_irq_enable,
	input wire logic trigger_pin_direction,
	input wire logic wait_mode,
	output logic xfer_ctrl_req_ff,
	output logic local_dma_req_ff,
	input wire logic xfer_done,
	output logic irq_request_ff
);

	localparam int CW = $clog2(CHANNELS);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ARM,
		ST_PICK,
		ST_CHARGE,
		ST_DISCH,
		ST_PRE,
		ST_MAIN,
		ST_JUDGE,
		ST_XFER,
		ST_XWAIT,
		ST_ADV,
		ST_DONE
	} state_t;

	// ****************************************
	// register storage
	// ****************************************
	logic start_ff;
	logic [1:0] trig_sel_ff;
	logic pre_en_ff;
	logic [CW-1:0] chan_sel_ff;
	logic scan_sel_ff;
	logic scan_order_ff;
	logic [CHANNELS-1:0] chan_en_ff;
	logic [SW-1:0] preset_ff;
	logic completion_flag_ff;
	logic flag_seen_ff;

	state_t state_ff;
	state_t nxt_state;
	logic [CW-1:0] cursor_ff;
	logic [CW-1:0] nxt_cursor;
	logic [3:0] phase_ff;
	logic [3:0] nxt_phase;
	logic [$clog2(touch_pkg::UNIT_DIV+1)-1:0] div_ff;
	logic tick_ff;
	logic pre_hi_ff;

	// two-stage synchronisers for pins
	logic sense_meta_ff;
	logic sense_sync_ff;
	logic trig_meta_ff;
	logic trig_sync_ff;
	logic trig_prev_ff;
	logic cmf_prev_ff;

	// running counts stay inside the counter unit; only the latched results and the step2 and done flags leave it
	wire step2;
	wire meas_done;
	wire [PW-1:0] data1;
	wire [PW-1:0] data2;

	// ****************************************
	// register decode
	// ****************************************
	wire wr_ctrl = wr_en & (addr == touch_pkg::UNIT_CONTROL_OFS);
	wire wr_mode = wr_en & (addr == touch_pkg::MEASURE_MODE_OFS);
	wire wr_chctl = wr_en & (addr == touch_pkg::CHANNEL_CONTROL_OFS);
	wire wr_chen = wr_en & (addr == touch_pkg::CHANNEL_ENABLE_OFS);
	wire wr_thr = wr_en & (addr == touch_pkg::THRESHOLD_CONTROL_OFS);
	wire wr_preset = wr_en & (addr == touch_pkg::SECONDARY_PRESET_OFS);
	wire wr_flag = wr_en & (addr == touch_pkg::UNIT_FLAG_OFS);
	wire rd_flag = rd_en & (addr == touch_pkg::UNIT_FLAG_OFS);
	wire start_wr1 = wr_ctrl & wr_data[touch_pkg::START_BIT];
	wire start_wr0 = wr_ctrl & ~wr_data[touch_pkg::START_BIT];
	// clearing only counts after the flag was seen as one
	wire flag_clr = wr_flag & ~wr_data[touch_pkg::FLAG_BIT] & flag_seen_ff;
	wire flag_set = (state_ff == ST_DONE);

	logic [touch_pkg::DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		unique case (addr)
			touch_pkg::UNIT_CONTROL_OFS: rd_mux[touch_pkg::START_BIT] = start_ff;
			touch_pkg::MEASURE_MODE_OFS: rd_mux[2:0] = {pre_en_ff, trig_sel_ff};
			touch_pkg::CHANNEL_CONTROL_OFS: rd_mux[4:0] = {scan_order_ff, scan_sel_ff, 3'(chan_sel_ff)};
			touch_pkg::CHANNEL_ENABLE_OFS: rd_mux[7:0] = 8'(chan_en_ff);
			touch_pkg::THRESHOLD_CONTROL_OFS: rd_mux[1:0] = threshold_field_ff;
			touch_pkg::SECONDARY_PRESET_OFS: rd_mux[4:0] = 5'(preset_ff);
			touch_pkg::UNIT_FLAG_OFS: rd_mux[touch_pkg::FLAG_BIT] = completion_flag_ff;
			touch_pkg::FIRST_RESULT_OFS: rd_mux[8:0] = 9'(data1);
			touch_pkg::SECOND_RESULT_OFS: rd_mux[8:0] = 9'(data2);
			touch_pkg::UNIT_STATUS_OFS: rd_mux[8:0] = {step2, 3'(cursor_ff), 1'b0, 4'(state_ff)};
			default: rd_mux = '0;
		endcase
	end

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			trig_sel_ff <= touch_pkg::TRIG_SOFTWARE;
			pre_en_ff <= 1'b0;
			chan_sel_ff <= '0;
			scan_sel_ff <= 1'b0;
			scan_order_ff <= 1'b0;
			chan_en_ff <= touch_pkg::CHANNEL_ENABLE_RST;
			threshold_field_ff <= touch_pkg::THRESHOLD_RST;
			preset_ff <= touch_pkg::SECONDARY_PRESET_RST;
		end else begin
			if (wr_mode) begin
				trig_sel_ff <= wr_data[touch_pkg::TRIG_LSB +: 2];
				pre_en_ff <= wr_data[touch_pkg::PRE_EN_BIT];
			end
			if (wr_chctl) begin
				chan_sel_ff <= wr_data[touch_pkg::CHSEL_LSB +: CW];
				scan_sel_ff <= wr_data[touch_pkg::SCAN_SEL_BIT];
				scan_order_ff <= wr_data[touch_pkg::SCAN_ORDER_BIT];
			end
			if (wr_chen) begin
				chan_en_ff <= wr_data[CHANNELS-1:0];
			end
			if (wr_thr) begin
				threshold_field_ff <= wr_data[1:0];
			end
			if (wr_preset) begin
				preset_ff <= wr_data[SW-1:0];
			end
		end
	end

	// start bit: software write wins over the hardware clear at completion
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			start_ff <= 1'b0;
		end else if (wr_ctrl) begin
			start_ff <= wr_data[touch_pkg::START_BIT];
		end else if (flag_set) begin
			start_ff <= 1'b0;
		end
	end

	// a new completion beats a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			completion_flag_ff <= 1'b0;
			flag_seen_ff <= 1'b0;
			irq_request_ff <= 1'b0;
			rd_data_ff <= '0;
		end else begin
			if (flag_set) begin
				completion_flag_ff <= 1'b1;
				irq_request_ff <= 1'b1;
			end else if (flag_clr) begin
				completion_flag_ff <= 1'b0;
				irq_request_ff <= 1'b0;
			end
			if (rd_flag & completion_flag_ff) begin
				flag_seen_ff <= 1'b1;
			end else if (flag_clr | flag_set) begin
				flag_seen_ff <= 1'b0;
			end
			rd_data_ff <= rd_en ? rd_mux : '0;
		end
	end

	// ****************************************
	// pin synchronisers and trigger edges
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sense_meta_ff <= 1'b0;
			sense_sync_ff <= 1'b0;
			trig_meta_ff <= 1'b1;
			trig_sync_ff <= 1'b1;
			trig_prev_ff <= 1'b1;
			cmf_prev_ff <= 1'b0;
		end else begin
			sense_meta_ff <= sense_pin_i;
			sense_sync_ff <= sense_meta_ff;
			trig_meta_ff <= external_trigger_pin;
			trig_sync_ff <= trig_meta_ff;
			trig_prev_ff <= trig_sync_ff;
			cmf_prev_ff <= compare_match_flag;
		end
	end

	wire cmf_rise = compare_match_flag & ~cmf_prev_ff;
	wire ext_fall = trig_prev_ff & ~trig_sync_ff;
	wire ext_ready = external_irq_enable & ~trigger_pin_direction;

	logic trig_hit;
	always_comb begin
		unique case (trig_sel_ff)
			touch_pkg::TRIG_SOFTWARE: trig_hit = 1'b1;
			touch_pkg::TRIG_TIMER: trig_hit = cmf_rise;
			touch_pkg::TRIG_EXTERNAL: trig_hit = ext_ready & ext_fall;
			default: trig_hit = 1'b0;
		endcase
	end

	// ****************************************
	// unit clock enable
	// ****************************************
	// the unit runs at the divided rate; the ratio is fixed at UNIT_DIV by the package
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			div_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= (div_ff == '0);
			if (div_ff == $bits(div_ff)'(touch_pkg::UNIT_DIV - 1)) begin
				div_ff <= '0;
			end else begin
				div_ff <= div_ff + 1'b1;
			end
		end
	end

	// ****************************************
	// channel walk
	// ****************************************
	// true when the cursor is the final channel of the chosen walk
	function automatic logic walk_end(input logic [CW-1:0] cur, input logic [CW-1:0] lim,
		input logic scan, input logic desc);
		walk_end = ~scan | (desc ? (cur == '0) : (cur == lim));
	endfunction

	wire last_chan = walk_end(cursor_ff, chan_sel_ff, scan_sel_ff, scan_order_ff);
	wire [CW-1:0] first_chan = (scan_sel_ff & ~scan_order_ff) ? '0 : chan_sel_ff;
	wire [CW-1:0] step_chan = scan_order_ff ? cursor_ff - 1'b1 : cursor_ff + 1'b1;
	wire phase_end = tick_ff & (phase_ff == '0);
	wire [3:0] phase_dec = tick_ff ? phase_ff - 1'b1 : phase_ff;

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_cursor = cursor_ff;
		nxt_phase = phase_dec;
		unique case (state_ff)
			ST_IDLE: begin
				if (start_wr1) begin
					nxt_state = ST_ARM;
				end
			end
			ST_ARM: begin
				if (trig_hit) begin
					nxt_cursor = first_chan;
					nxt_state = ST_PICK;
				end
			end
			ST_PICK: begin
				nxt_phase = 4'(touch_pkg::CHARGE_TICKS - 1);
				nxt_state = chan_en_ff[cursor_ff] ? ST_CHARGE : ST_ADV;
			end
			ST_CHARGE: begin
				if (phase_end) begin
					nxt_phase = 4'(touch_pkg::DISCHARGE_TICKS - 1);
					nxt_state = ST_DISCH;
				end
			end
			ST_DISCH: begin
				if (phase_end) begin
					nxt_phase = 4'(touch_pkg::SETTLE_TICKS - 1);
					nxt_state = ST_PRE;
				end
			end
			ST_PRE: begin
				if (phase_end) begin
					nxt_phase = '0;
					nxt_state = ST_MAIN;
				end
			end
			ST_MAIN: begin
				if (phase_end) begin
					nxt_state = ST_JUDGE;
				end
			end
			ST_JUDGE: begin
				nxt_phase = 4'(touch_pkg::DISCHARGE_TICKS - 1);
				nxt_state = meas_done ? ST_XFER : ST_DISCH;
			end
			ST_XFER: begin
				nxt_state = ST_XWAIT;
			end
			ST_XWAIT: begin
				if (xfer_done) begin
					nxt_state = ST_ADV;
				end
			end
			ST_ADV: begin
				if (last_chan) begin
					nxt_state = ST_DONE;
				end else begin
					nxt_cursor = step_chan;
					nxt_state = ST_PICK;
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
		// a software stop abandons the walk and leaves the counters alone
		if (start_wr0) begin
			nxt_state = ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			cursor_ff <= '0;
			phase_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cursor_ff <= nxt_cursor;
			phase_ff <= nxt_phase;
		end
	end

	// ****************************************
	// sampling
	// ****************************************
	// the pin buffer applies the threshold; one judgement per discharge cycle
	wire sample_pre = (state_ff == ST_PRE) & phase_end;
	wire sample_main = (state_ff == ST_MAIN) & phase_end;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pre_hi_ff <= 1'b0;
		end else if (sample_pre) begin
			pre_hi_ff <= sense_sync_ff;
		end
	end

	touch_count_unit #(
		.PW(PW),
		.SW(SW)
	) u_count (
		.clk_sys(clk_sys),
		.srst(srst),
		.clear(state_ff == ST_PICK),
		.sample_en(sample_main),
		.pre_en(pre_en_ff),
		.pre_hi(pre_hi_ff),
		.main_hi(sense_sync_ff),
		.preset(preset_ff),
		.primary_ff(),
		.secondary_ff(),
		.step2_ff(step2),
		.done_ff(meas_done),
		.data1_ff(data1),
		.data2_ff(data2)
	);

	// ****************************************
	// pins and transfer requests
	// ****************************************
	wire drive_charge = (state_ff == ST_CHARGE);
	wire drive_disch = (state_ff == ST_DISCH);
	wire measuring = (state_ff != ST_IDLE) & (state_ff != ST_ARM) & (state_ff != ST_DONE);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			charge_pin_o_ff <= 1'b0;
			charge_pin_oe_n_ff <= 1'b1;
			sense_pin_o_ff <= 1'b0;
			sense_pin_oe_n_ff <= 1'b1;
			discharge_pin_o_ff <= 1'b0;
			discharge_pin_oe_n_ff <= 1'b1;
			channel_on_ff <= '0;
			xfer_ctrl_req_ff <= 1'b0;
			local_dma_req_ff <= 1'b0;
		end else begin
			charge_pin_o_ff <= drive_charge;
			charge_pin_oe_n_ff <= ~drive_charge;
			sense_pin_o_ff <= 1'b0;
			sense_pin_oe_n_ff <= ~drive_disch;
			discharge_pin_o_ff <= 1'b0;
			discharge_pin_oe_n_ff <= ~drive_disch;
			channel_on_ff <= measuring ? CHANNELS'(1) << cursor_ff : '0;
			xfer_ctrl_req_ff <= (state_ff == ST_XFER) & ~wait_mode;
			local_dma_req_ff <= (state_ff == ST_XFER) & wait_mode;
		end
	end

endmodule

// [sim/touch_electrode_model.sv]
// behavioural touch electrode with a single charge store for the selected channel
`timescale 1ns/1ps
module touch_electrode_model #(
	parameter int CHANNELS = 8
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [CHANNELS-1:0] channel_on,
	input wire logic sense_o,
	input wire logic sense_oe_n,
	input wire logic discharge_oe_n,
	input wire logic charge_o,
	input wire logic charge_oe_n,
	input wire logic [CHANNELS-1:0][7:0] levels,
	output logic sense_level
);
	logic [7:0] charge_ff;
	logic [7:0] nxt_charge;
	logic [7:0] full;
	logic dis_q_ff;
	logic tog_ff;
	always_comb begin
		full = 8'h00;
		for (int i = 0; i < CHANNELS; i++) begin
			if (channel_on[i]) begin
				full = levels[i];
			end
		end
	end
	// charging refills the channel, each discharge pulse drains one step
	assign nxt_charge = (!charge_oe_n && charge_o) ? full :
		(dis_q_ff && !discharge_oe_n && charge_ff != 8'h00) ? charge_ff - 8'h01 : charge_ff;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			charge_ff <= 8'h00;
			dis_q_ff <= 1'b1;
			tog_ff <= 1'b0;
		end else begin
			charge_ff <= nxt_charge;
			dis_q_ff <= discharge_oe_n;
			tog_ff <= ~tog_ff;
		end
	end
	// an unselected electrode floats, so it shows a changing level, never a stale one
	assign sense_level = (channel_on == '0) ? tog_ff : (!sense_oe_n ? sense_o : (charge_ff != 8'h00));
endmodule

// [sim/touch_measure_props.sv]
// concurrent checks on the touch measurement ports
`timescale 1ns/1ps
module touch_measure_props #(
	parameter int CHANNELS = 8
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [touch_pkg::ADDR_W-1:0] addr,
	input wire logic [touch_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [touch_pkg::DATA_W-1:0] rd_data_ff,
	input wire logic sense_pin_o_ff,
	input wire logic sense_pin_oe_n_ff,
	input wire logic discharge_pin_o_ff,
	input wire logic discharge_pin_oe_n_ff,
	input wire logic charge_pin_oe_n_ff,
	input wire logic [CHANNELS-1:0] channel_on_ff,
	input wire logic xfer_ctrl_req_ff,
	input wire logic local_dma_req_ff,
	input wire logic irq_request_ff
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	// ****************************************
	// completion flag
	// ****************************************
	a_irq_hold: assert property (
		irq_request_ff && !(wr_en && addr == touch_pkg::UNIT_FLAG_OFS) |=> irq_request_ff)
		else $error("completion request dropped");
	a_flag_read: assert property (
		rd_en && addr == touch_pkg::UNIT_FLAG_OFS |=> rd_data_ff[0] == $past(irq_request_ff))
		else $error("flag read differs from request");
	a_flag_clear: assert property (
		$fell(irq_request_ff) |-> $past(wr_en) && $past(addr) == touch_pkg::UNIT_FLAG_OFS && !$past(wr_data[0]))
		else $error("request fell without a flag write");
	// ****************************************
	// pins and sequencing
	// ****************************************
	a_charge_alone: assert property (
		!charge_pin_oe_n_ff |-> discharge_pin_oe_n_ff && sense_pin_oe_n_ff)
		else $error("charge overlaps discharge");
	a_discharge_pair: assert property (
		discharge_pin_oe_n_ff == sense_pin_oe_n_ff)
		else $error("sense and discharge drive differ");
	a_discharge_low: assert property (
		!discharge_pin_oe_n_ff |-> !discharge_pin_o_ff && !sense_pin_o_ff)
		else $error("discharge drives high");
	a_discharge_brief: assert property (
		$fell(discharge_pin_oe_n_ff) |-> ##[1:8] discharge_pin_oe_n_ff)
		else $error("discharge not released");
	a_one_channel: assert property (
		$onehot0(channel_on_ff))
		else $error("more than one channel selected");
	a_stop_idle: assert property (
		wr_en && addr == touch_pkg::UNIT_CONTROL_OFS && !wr_data[0] |-> ##[1:3] channel_on_ff == '0)
		else $error("stop left a channel selected");
	a_req_exclusive: assert property (
		!(xfer_ctrl_req_ff && local_dma_req_ff))
		else $error("both transfer requests raised");
	a_req_pulse: assert property (
		xfer_ctrl_req_ff || local_dma_req_ff |=> !(xfer_ctrl_req_ff || local_dma_req_ff))
		else $error("transfer request longer than one cycle");
endmodule
bind touch_measure touch_measure_props #(.CHANNELS(CHANNELS)) chk_u (.clk_sys, .srst, .addr, .wr_data, .wr_en,
	.rd_en, .rd_data_ff, .sense_pin_o_ff, .sense_pin_oe_n_ff, .discharge_pin_o_ff, .discharge_pin_oe_n_ff,
	.charge_pin_oe_n_ff, .channel_on_ff, .xfer_ctrl_req_ff, .local_dma_req_ff, .irq_request_ff);

// [sim/touch_measure_bench.sv]
// self-checking bench for the capacitive touch measurement block
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module touch_measure_bench;
	typedef struct {
		string name;
		logic [15:0] val;
	} note_t;
	logic clk_sys;
	logic srst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wr_data = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic compare_match_flag = 1'b0;
	logic external_trigger_pin = 1'b1;
	logic external_irq_enable = 1'b0;
	logic trigger_pin_direction = 1'b0;
	logic wait_mode = 1'b0;
	logic xfer_done = 1'b0;
	logic rd_q = 1'b0;
	logic [15:0] rd_data_ff;
	logic sense_pin_i, sense_pin_o_ff, sense_pin_oe_n_ff, discharge_pin_o_ff, discharge_pin_oe_n_ff;
	logic charge_pin_o_ff, charge_pin_oe_n_ff, xfer_ctrl_req_ff, local_dma_req_ff, irq_request_ff;
	logic [7:0] channel_on_ff;
	logic [1:0] threshold_field_ff;
	logic [1:0] thr;
	logic [7:0][7:0] levels;
	logic [8:0] exp_data;
	int failures = 0;
	int n_tests = 0;
	int busy_cnt = 0;
	int last_ch;
	note_t notes[$];
	touch_measure dut_u (.clk_sys, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data_ff, .sense_pin_i,
		.sense_pin_o_ff, .sense_pin_oe_n_ff, .discharge_pin_o_ff, .discharge_pin_oe_n_ff, .charge_pin_o_ff,
		.charge_pin_oe_n_ff, .channel_on_ff, .threshold_field_ff, .compare_match_flag, .external_trigger_pin,
		.external_irq_enable, .trigger_pin_direction, .wait_mode, .xfer_ctrl_req_ff, .local_dma_req_ff,
		.xfer_done, .irq_request_ff);
	touch_electrode_model model_u (.clk_sys, .srst, .channel_on(channel_on_ff), .sense_o(sense_pin_o_ff),
		.sense_oe_n(sense_pin_oe_n_ff), .discharge_oe_n(discharge_pin_oe_n_ff), .charge_o(charge_pin_o_ff),
		.charge_oe_n(charge_pin_oe_n_ff), .levels, .sense_level(sense_pin_i));
	initial begin
		clk_sys = 1'b0;
		// 10 MHz here, so the fixed halving gives the unit its 5 MHz rate
		forever #50 clk_sys = ~clk_sys;
	end
	// ****************************************
	// bus tasks and result watcher
	// ****************************************
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] d);
		notes.push_back('{$sformatf("read %h", a), d});
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
	endtask
	task automatic take(input logic [15:0] got);
		note_t n;
		if (notes.size() == 0) begin
			failures++;
			$display("MISMATCH unexpected expected %h seen %h", 16'h0000, got);
		end else begin
			n = notes.pop_front();
			`CHECK(n.name, n.val, got)
		end
	endtask
	// the far side stalls a few cycles before confirming each transfer
	always @(posedge clk_sys) begin
		rd_q <= rd_en;
		xfer_done <= (busy_cnt == 1);
		if (busy_cnt != 0) begin
			busy_cnt <= busy_cnt - 1;
		end
		if (rd_q) begin
			take(rd_data_ff);
		end
		if (xfer_ctrl_req_ff === 1'b1 || local_dma_req_ff === 1'b1) begin
			take({7'h00, local_dma_req_ff, channel_on_ff});
			busy_cnt <= 2 + $urandom_range(0, 6);
		end
	end
	task automatic wait_on(input bit for_irq);
		int i;
		for (i = 0; i < 20000; i++) begin
			@(posedge clk_sys);
			if (for_irq ? irq_request_ff === 1'b1 : channel_on_ff !== 8'h00) break;
		end
		if (i == 20000) begin
			failures++;
			$display("MISMATCH wait expected %h seen %h", 1'b1, 1'b0);
			print_verdict();
		end
	endtask
	// notes the channel order of requests and the last channel's results, then arms
	task automatic measure(input logic [1:0] trig, input logic pre, input logic [4:0] chctl, input logic [7:0] en);
		int k;
		int c;
		last_ch = -1;
		wr(touch_pkg::CHANNEL_ENABLE_OFS, {8'h00, en});
		wr(touch_pkg::CHANNEL_CONTROL_OFS, {11'h000, chctl});
		wr(touch_pkg::MEASURE_MODE_OFS, {13'h0000, pre, trig});
		for (k = 0; k < 8; k++) begin
			if (!chctl[3]) c = (k == 0) ? int'(chctl[2:0]) : -1;
			else if (k > int'(chctl[2:0])) c = -1;
			else c = chctl[4] ? int'(chctl[2:0]) - k : k;
			if (c >= 0 && en[c]) begin
				notes.push_back('{"request", {7'h00, wait_mode, 8'(1 << c)}});
				last_ch = c;
			end
		end
		if (last_ch >= 0) exp_data = 9'(levels[last_ch] - 8'h01) << pre;
		wr(touch_pkg::UNIT_CONTROL_OFS, 16'h0001);
	endtask
	task automatic finish(input string name);
		wait_on(1'b1);
		if (last_ch >= 0) begin
			rd(touch_pkg::FIRST_RESULT_OFS, {7'h00, exp_data});
			rd(touch_pkg::SECOND_RESULT_OFS, {7'h00, exp_data});
		end
		rd(touch_pkg::UNIT_CONTROL_OFS, 16'h0000);
		wr(touch_pkg::UNIT_FLAG_OFS, 16'h0000);
		@(posedge clk_sys);
		`CHECK("irq kept", 1'b1, irq_request_ff)
		rd(touch_pkg::UNIT_FLAG_OFS, 16'h0001);
		wr(touch_pkg::UNIT_FLAG_OFS, 16'h0000);
		@(posedge clk_sys);
		`CHECK("irq cleared", 1'b0, irq_request_ff)
		$display("test %s done", name);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h6e42));
		for (int i = 0; i < 8; i++) levels[i] = 8'(2 + $urandom_range(0, 18));
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		rd(touch_pkg::CHANNEL_ENABLE_OFS, 16'h0000);
		rd(touch_pkg::SECONDARY_PRESET_OFS, 16'h0007);
		rd(touch_pkg::MEASURE_MODE_OFS, 16'h0000);
		rd(4'hf, 16'h0000);
		`CHECK("pins idle", 3'h7, {sense_pin_oe_n_ff, discharge_pin_oe_n_ff, charge_pin_oe_n_ff})
		thr = 2'($urandom_range(0, 3));
		wr(touch_pkg::THRESHOLD_CONTROL_OFS, {14'h0000, thr});
		rd(touch_pkg::THRESHOLD_CONTROL_OFS, {14'h0000, thr});
		`CHECK("threshold", thr, threshold_field_ff)
		wr(touch_pkg::SECONDARY_PRESET_OFS, {11'h000, 5'(1 + $urandom_range(0, 7))});
		$display("test reset done");
		measure(touch_pkg::TRIG_SOFTWARE, 1'b0, {2'b00, 3'($urandom_range(0, 7))}, 8'hff);
		finish("software single");
		wait_mode <= 1'b1;
		measure(touch_pkg::TRIG_SOFTWARE, 1'b1, 5'h0b, 8'h0a);
		finish("scan ascending");
		wait_mode <= 1'b0;
		measure(touch_pkg::TRIG_TIMER, 1'b0, 5'h1f, 8'h84);
		repeat (20) @(posedge clk_sys);
		`CHECK("timer held", 8'h00, channel_on_ff)
		compare_match_flag <= 1'b1;
		finish("timer scan descending");
		compare_match_flag <= 1'b0;
		wait_mode <= 1'b1;
		external_irq_enable <= 1'b1;
		measure(touch_pkg::TRIG_EXTERNAL, 1'b0, 5'h06, 8'h40);
		// a falling edge while the pin is set as output must not start
		trigger_pin_direction <= 1'b1;
		external_trigger_pin <= 1'b0;
		repeat (20) @(posedge clk_sys);
		`CHECK("external held", 8'h00, channel_on_ff)
		external_trigger_pin <= 1'b1;
		trigger_pin_direction <= 1'b0;
		repeat (4) @(posedge clk_sys);
		external_trigger_pin <= 1'b0;
		finish("external single");
		external_trigger_pin <= 1'b1;
		measure(touch_pkg::TRIG_SOFTWARE, 1'b0, 5'h01, 8'hfd);
		finish("single disabled");
		measure(2'h1, 1'b0, 5'h00, 8'h01);
		repeat (30) @(posedge clk_sys);
		`CHECK("reserved trigger", 8'h00, channel_on_ff)
		wr(touch_pkg::UNIT_CONTROL_OFS, 16'h0000);
		notes.delete();
		measure(touch_pkg::TRIG_SOFTWARE, 1'b0, 5'h00, 8'h01);
		wait_on(1'b0);
		repeat (24) @(posedge clk_sys);
		wr(touch_pkg::UNIT_CONTROL_OFS, 16'h0000);
		notes.delete();
		repeat (3) @(posedge clk_sys);
		`CHECK("stopped", 8'h00, channel_on_ff)
		// stopped before any low, so the last measured channel's result must survive
		rd(touch_pkg::FIRST_RESULT_OFS, {7'h00, 9'(levels[6] - 8'h01)});
		repeat (600) @(posedge clk_sys);
		`CHECK("no irq after stop", 1'b0, irq_request_ff)
		$display("test stop done");
		print_verdict();
	end
endmodule
